/* File: dv/rcl_cfg_loader_checker.sv */
// port assertions for the configuration loader
`timescale 1ns/100ps
`default_nettype none

module rcl_cfg_loader_checker (
  input wire logic       CLK_SYS_I,
  input wire logic       RSTN_I,
  input wire logic       PSEL_I,
  input wire logic       PENABLE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic       PREADY_O,
  input wire logic       PSLVERR_O,
  input wire logic [1:0] MODE_LVL_I,
  input wire logic       READ_EN_N_I,
  input wire logic       SCL_O,
  input wire logic       SCL_OE_O,
  input wire logic       SDA_O,
  input wire logic       SDA_OE_O,
  input wire logic       ALL_DONE_N_O,
  input wire logic       ALL_DONE_N_OE_O
);
  // ==========================================================================
  // scl low phase length
  logic [8:0] lo_cnt_r;
  logic [8:0] lo_cnt_nxt;
  always_comb lo_cnt_nxt = SCL_OE_O ? lo_cnt_r + 9'h1 : 9'h0;
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) lo_cnt_r <= 9'h0;
    else lo_cnt_r <= lo_cnt_nxt;
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  // ==========================================================================
  // assertions
  a_od_low_only: assert property (!SCL_O && !SDA_O && !ALL_DONE_N_O)
    else $error("open drain output drives high");
  a_scl_low_time: assert property ($fell(SCL_OE_O) |-> lo_cnt_r inside {[9'hBC:9'hC0]})
    else $error("scl low phase length wrong");
  a_pin_quiet: assert property (MODE_LVL_I == 2'h0 [*6] |-> !SCL_OE_O && !SDA_OE_O)
    else $error("bus driven in pin mode");
  a_done_mode: assert property (MODE_LVL_I != 2'h1 [*6] |-> !ALL_DONE_N_OE_O)
    else $error("load complete outside master mode");
  a_load_once: assert property (ALL_DONE_N_OE_O |-> !$rose(SCL_OE_O))
    else $error("second eeprom load started");
  a_done_quiet: assert property ($rose(ALL_DONE_N_OE_O) |-> !SCL_OE_O && !SDA_OE_O && !READ_EN_N_I)
    else $error("load complete while bus busy");
  a_unmapped_err: assert property (PSEL_I && PENABLE_I && PADDR_I == 8'h04 |-> PSLVERR_O)
    else $error("no error on unmapped address");
  a_mapped_ok: assert property (PSEL_I && PENABLE_I && PADDR_I == 8'h1C |-> PREADY_O && !PSLVERR_O)
    else $error("mapped access refused");
endmodule // rcl_cfg_loader_checker

bind rcl_cfg_loader rcl_cfg_loader_checker u_chk (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .MODE_LVL_I(MODE_LVL_I),
  .READ_EN_N_I(READ_EN_N_I), .SCL_O(SCL_O), .SCL_OE_O(SCL_OE_O), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .ALL_DONE_N_O(ALL_DONE_N_O), .ALL_DONE_N_OE_O(ALL_DONE_N_OE_O));
`default_nettype wire

/* File: dv/rcl_ee_model.sv */
// behavioural serial eeprom answering at 8-bit address 0xA0
`timescale 1ns/100ps
`default_nettype none

module rcl_ee_model (
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic nack_i,
  output logic      oe_o
);
  logic [7:0] sh, mem [8];
  logic       act, hdr, rd, ack;
  logic [2:0] ptr;
  int         bitn;
  initial begin
    oe_o = 1'b0;
    act = 1'b0;
    for (int i = 0; i < 8; i++) mem[i] = 8'(i * 3 + 1);
  end
  // only changes sda while scl is low, so it never fakes a start or stop
  always @(negedge sda_i) if (scl_i) begin
    act = 1'b1;
    hdr = 1'b1;
    rd = 1'b0;
    bitn = -1;
  end
  always @(posedge sda_i) if (scl_i) act = 1'b0;
  always @(posedge scl_i) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda_i};
    else ack = sda_i;
  end
  always @(negedge scl_i) if (act) begin
    bitn++;
    if (bitn == 8 && hdr) begin
      rd = sh[0];
      act = sh[7:1] == 7'h50 && !nack_i;
      oe_o = act;
    end else if (bitn == 8) begin
      if (!rd) ptr = sh[2:0];
      oe_o = !rd;
    end else if (bitn == 9) begin
      bitn = 0;
      if (rd && !hdr && !ack) ptr++;
      oe_o = rd && (hdr || !ack) && !mem[ptr][7];
      hdr = 1'b0;
    end else if (rd && !hdr) oe_o = !mem[ptr][7 - bitn];
  end
endmodule // rcl_ee_model
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the configuration loader
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import rcl_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rden_n = 1'b1, nack = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwd = 32'h0, prd, bst, rd;
  logic [1:0]  mode = 2'h0, hia = 2'h2, loa = 2'h1, hib = 2'h3, lob = 2'h3;
  logic        pready, perr, err, scl_oe, sda_oe, ee_oe, dn_oe, h_scl = 1'b1, h_sda = 1'b1;
  // the foreign host's lines stay released outside its frames
  wire logic   scl = !scl_oe & h_scl;
  wire logic   sda = !(sda_oe | ee_oe) & h_sda;
  int          mismatches = 0, comparisons = 0, n;

  rcl_cfg_loader #(.LOAD_CYC(2000)) DUT (.CLK_SYS_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr),
    .MODE_LVL_I(mode), .BOOST_HI_GRP_A_I(hia), .BOOST_LO_GRP_A_I(loa), .BOOST_HI_GRP_B_I(hib),
    .BOOST_LO_GRP_B_I(lob), .READ_EN_N_I(rden_n), .SCL_I(scl), .SCL_O(), .SCL_OE_O(scl_oe), .SDA_I(sda),
    .SDA_O(), .SDA_OE_O(sda_oe), .ALL_DONE_N_O(), .ALL_DONE_N_OE_O(dn_oe), .BOOST_STEP_O(bst));
  rcl_ee_model u_ee (.scl_i(scl), .sda_i(sda), .nack_i(nack), .oe_o(ee_oe));

  initial begin
    forever #5 clk = ~clk;
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      end_sim();
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_pin();
    tick(20);
    chk("boost pin", 32'hFFFF9999, bst);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("slave addr", 32'h2A, {25'h0, rd[14:8]});
    chk("straps ready", 32'h1, {31'h0, rd[ST_CAP_BIT]});
    hia <= 2'h0;
    lob <= 2'h1;
    tick(20);
    chk("boost held", 32'hFFFF9999, bst);
    $display("test pin mode done");
  endtask
  task automatic t_reg();
    mode <= MODE_SLAVE;
    apb(1'b1, 8'h1C, 32'hFFFFFFF5);
    apb(1'b0, 8'h1C, 32'h0);
    chk("boost ch3 reg", 32'h5, rd);
    tick(8);
    chk("boost regs", 32'h00005000, bst);
    apb(1'b0, 8'h04, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test register mode done");
  endtask
  // foreign host writes channel 5 through the group-b address; phases kept slow for the spike filter
  task automatic t_slave();
    logic [26:0] f;
    f = {8'h56, 1'b1, 8'h01, 1'b1, 8'h0C, 1'b1};
    h_sda <= 1'b0;
    tick(130);
    for (int i = 26; i >= 0; i--) begin
      h_scl <= 1'b0;
      tick(50);
      h_sda <= f[i];
      tick(80);
      h_scl <= 1'b1;
      tick(120);
      if (i % 9 == 0) chk("slave ack", 32'h1, {31'h0, sda_oe});
    end
    h_scl <= 1'b0;
    tick(50);
    h_sda <= 1'b0;
    tick(80);
    h_scl <= 1'b1;
    tick(120);
    h_sda <= 1'b1;
    tick(130);
    chk("boost slave", 32'h00C05000, bst);
    $display("test serial slave done");
  endtask
  task automatic t_master();
    rden_n <= 1'b0;
    mode <= MODE_MASTER;
    // the host stays quiet during the load, so no arbitration is needed
    for (n = 0; n < 60000 && dn_oe !== 1'b1; n++) @(posedge clk);
    chk("load done", 32'h1, {31'h0, dn_oe});
    if (dn_oe !== 1'b1) end_sim();
    chk("eeprom boost", 32'h630DA741, bst);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("load ok", 32'h1, {31'h0, rd[ST_OK_BIT]});
    $display("test eeprom load done");
  endtask
  task automatic t_fail();
    nack <= 1'b1;
    rstn <= 1'b0;
    tick(16);
    rstn <= 1'b1;
    for (n = 0; n < 5000 && rd[ST_FAIL_BIT] !== 1'b1; n++) apb(1'b0, REG_STATUS, 32'h0);
    chk("load fail", 32'h1, {31'h0, rd[ST_FAIL_BIT]});
    chk("done released", 32'h0, {31'h0, dn_oe});
    $display("test eeprom failure done");
  endtask

  initial begin
    tick(16);
    rstn <= 1'b1;
    t_pin();
    t_reg();
    t_slave();
    t_master();
    t_fail();
    end_sim();
  end
endmodule // testbench
`default_nettype wire

/* File: hw/rcl_cfg_loader.sv */
// configuration loader: straps, eeprom self-load master, serial slave, apb registers
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none

module rcl_cfg_loader
  import rcl_pkg::*;
#(
  parameter int LOAD_CYC = LOAD_CYC_DFLT
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RSTN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic [1:0]  MODE_LVL_I,
  input  wire logic [1:0]  BOOST_HI_GRP_A_I,
  input  wire logic [1:0]  BOOST_LO_GRP_A_I,
  input  wire logic [1:0]  BOOST_HI_GRP_B_I,
  input  wire logic [1:0]  BOOST_LO_GRP_B_I,
  input  wire logic        READ_EN_N_I,
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE_O,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  output logic             ALL_DONE_N_O,
  output logic             ALL_DONE_N_OE_O,
  output logic      [31:0] BOOST_STEP_O
);

  // ==========================================================================
  // input synchronisers
  logic [1:0]  bus_f;
  logic [10:0] pin_f;
  logic        scl_f;
  logic        sda_f;
  logic [1:0]  mode;
  logic        rd_en_n;
  logic [7:0]  strap_f;

  rcl_in_filter #(.W(2), .FILT(BUS_FILT_CYC), .RST_VAL(2'h3)) u_bus_filt (
    .clk_i  (CLK_SYS_I),
    .rstn_i (RSTN_I),
    .d_i    ({SCL_I, SDA_I}),
    .q_o    (bus_f)
  );

  rcl_in_filter #(.W(11), .FILT(PIN_FILT_CYC), .RST_VAL(11'h100)) u_pin_filt (
    .clk_i  (CLK_SYS_I),
    .rstn_i (RSTN_I),
    .d_i    ({MODE_LVL_I, READ_EN_N_I, BOOST_HI_GRP_A_I, BOOST_LO_GRP_A_I,
              BOOST_HI_GRP_B_I, BOOST_LO_GRP_B_I}),
    .q_o    (pin_f)
  );

  assign scl_f   = bus_f[1];
  assign sda_f   = bus_f[0];
  assign mode    = pin_f[10:9];
  assign rd_en_n = pin_f[8];
  assign strap_f = pin_f[7:0];

  // ==========================================================================
  // power-up strap capture
  logic [7:0] cap_r;
  logic [7:0] cap_nxt;
  logic [2:0] cap_cnt_r;
  logic [2:0] cap_cnt_nxt;
  logic       cap_done;
  logic [6:0] slv_addr_a;
  logic [6:0] slv_addr_b;

  assign cap_done = (cap_cnt_r == CAP_DLY);

  // straps are frozen once the synchroniser has settled after reset
  always_comb begin
    cap_nxt     = cap_r;
    cap_cnt_nxt = cap_cnt_r;
    if (!cap_done) begin
      cap_cnt_nxt = cap_cnt_r + 3'h1;
      cap_nxt     = strap_f;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cap_r     <= 8'h00;
      cap_cnt_r <= 3'h0;
    end else begin
      cap_r     <= cap_nxt;
      cap_cnt_r <= cap_cnt_nxt;
    end
  end

  // the group-a boost straps double as slave id straps
  assign slv_addr_a = SLV_BASE + {2'h0, cap_r[7:4], 1'b0};
  assign slv_addr_b = slv_addr_a + 7'h01;

  // ==========================================================================
  // eeprom self-load master
  rcl_mst_t    m_st_r;
  rcl_mst_t    m_st_nxt;
  logic [1:0]  m_ph_r;
  logic [1:0]  m_ph_nxt;
  logic [7:0]  m_tmr_r;
  logic [7:0]  m_tmr_nxt;
  logic [3:0]  m_bit_r;
  logic [3:0]  m_bit_nxt;
  logic [3:0]  m_step_r;
  logic [3:0]  m_step_nxt;
  logic [7:0]  m_sh_r;
  logic [7:0]  m_sh_nxt;
  logic        m_scl_low_r;
  logic        m_scl_low_nxt;
  logic        m_sda_low_r;
  logic        m_sda_low_nxt;
  logic        m_used_r;
  logic        m_used_nxt;
  logic [19:0] ld_cnt_r;
  logic [19:0] ld_cnt_nxt;
  logic        ld_due;
  logic        m_tx;
  logic        m_drv;
  logic        ee_wr;
  logic [2:0]  ee_ch;

  assign ld_due = (ld_cnt_r >= 20'(LOAD_CYC));
  assign m_tx   = (m_step_r < EE_RD_FIRST);

  always_comb begin
    m_st_nxt      = m_st_r;
    m_ph_nxt      = m_ph_r;
    m_tmr_nxt     = m_tmr_r + 8'h01;
    m_bit_nxt     = m_bit_r;
    m_step_nxt    = m_step_r;
    m_sh_nxt      = m_sh_r;
    m_scl_low_nxt = m_scl_low_r;
    m_sda_low_nxt = m_sda_low_r;
    m_used_nxt    = m_used_r;
    ld_cnt_nxt    = ld_cnt_r;
    ee_wr         = 1'b0;
    ee_ch         = 3'(m_step_r - EE_RD_FIRST);
    // address and data of a write byte, and the ack slot of a read byte; ack low except after the last byte read
    if (m_bit_r[3]) begin
      m_drv = !m_tx && (m_step_r != EE_RD_LAST);
    end else begin
      m_drv = m_tx && !m_sh_r[7];
    end
    if (!m_st_r[0] && !ld_due) begin
      ld_cnt_nxt = ld_cnt_r + 20'h00001;
    end
    unique case (m_st_r)
      M_IDLE: begin
        m_tmr_nxt = 8'h00;
        if (mode == MODE_MASTER && cap_done && !m_used_r && !rd_en_n) begin
          m_st_nxt   = M_START;
          m_ph_nxt   = 2'h0;
          m_step_nxt = 4'h0;
          m_used_nxt = 1'b1;
        end
      end
      M_START: begin
        if (m_ph_r == 2'h0) begin
          m_scl_low_nxt = 1'b1;
          m_sda_low_nxt = 1'b0;
          if (m_tmr_r == TC_LOW) begin
            m_ph_nxt  = 2'h1;
            m_tmr_nxt = 8'h00;
          end
        end else if (m_ph_r == 2'h1) begin
          m_scl_low_nxt = 1'b0;
          if (m_tmr_r == TC_SU_STA) begin
            m_ph_nxt      = 2'h2;
            m_tmr_nxt     = 8'h00;
            m_sda_low_nxt = 1'b1;
          end
        end else if (m_tmr_r == TC_HD_STA) begin
          m_st_nxt      = M_BIT;
          m_ph_nxt      = 2'h0;
          m_tmr_nxt     = 8'h00;
          m_bit_nxt     = 4'h0;
          m_scl_low_nxt = 1'b1;
          m_sh_nxt      = (m_step_r == EE_STEP_RS) ? EE_DEV_RD : EE_DEV_WR;
        end
      end
      M_BIT: begin
        if (m_ph_r == 2'h0) begin
          if (m_tmr_r == TC_HD_DAT) begin
            m_sda_low_nxt = m_drv;
          end
          if (m_tmr_r == TC_LOW) begin
            m_ph_nxt      = 2'h1;
            m_tmr_nxt     = 8'h00;
            m_scl_low_nxt = 1'b0;
          end
        end else if (m_tmr_r == TC_HIGH) begin
          m_ph_nxt      = 2'h0;
          m_tmr_nxt     = 8'h00;
          m_scl_low_nxt = 1'b1;
          if (!m_bit_r[3]) begin
            m_sh_nxt  = {m_sh_r[6:0], sda_f};
            m_bit_nxt = m_bit_r + 4'h1;
          end else if (m_tx && sda_f) begin
            m_st_nxt  = M_STOP;
            m_step_nxt = 4'hF;
          end else begin
            m_bit_nxt = 4'h0;
            ee_wr     = !m_tx;
            if (m_step_r == EE_RD_LAST) begin
              m_st_nxt = M_STOP;
            end else if (m_step_r == EE_STEP_WA) begin
              m_st_nxt   = M_START;
              m_step_nxt = EE_STEP_RS;
            end else begin
              m_step_nxt = m_step_r + 4'h1;
              m_sh_nxt   = EE_WORD;
            end
          end
        end
      end
      M_STOP: begin
        if (m_ph_r == 2'h0) begin
          if (m_tmr_r == TC_HD_DAT) begin
            m_sda_low_nxt = 1'b1;
          end
          if (m_tmr_r == TC_LOW) begin
            m_ph_nxt      = 2'h1;
            m_tmr_nxt     = 8'h00;
            m_scl_low_nxt = 1'b0;
          end
        end else if (m_tmr_r == TC_SU_STO) begin
          m_sda_low_nxt = 1'b0;
          m_st_nxt      = (m_step_r == 4'hF) ? M_FAIL : M_DONE;
        end
      end
      M_DONE, M_FAIL: begin
        m_tmr_nxt = 8'h00;
      end
      default: begin
        m_st_nxt      = M_FAIL;
        m_scl_low_nxt = 1'b0;
        m_sda_low_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      m_st_r      <= M_IDLE;
      m_ph_r      <= 2'h0;
      m_tmr_r     <= 8'h00;
      m_bit_r     <= 4'h0;
      m_step_r    <= 4'h0;
      m_sh_r      <= 8'h00;
      m_scl_low_r <= 1'b0;
      m_sda_low_r <= 1'b0;
      m_used_r    <= 1'b0;
      ld_cnt_r    <= 20'h00000;
    end else begin
      m_st_r      <= m_st_nxt;
      m_ph_r      <= m_ph_nxt;
      m_tmr_r     <= m_tmr_nxt;
      m_bit_r     <= m_bit_nxt;
      m_step_r    <= m_step_nxt;
      m_sh_r      <= m_sh_nxt;
      m_scl_low_r <= m_scl_low_nxt;
      m_sda_low_r <= m_sda_low_nxt;
      m_used_r    <= m_used_nxt;
      ld_cnt_r    <= ld_cnt_nxt;
    end
  end

  // ==========================================================================
  // serial slave, write only
  logic       scl_q_r;
  logic       sda_q_r;
  logic       s_act_r;
  logic       s_act_nxt;
  logic [3:0] s_bit_r;
  logic [3:0] s_bit_nxt;
  logic [1:0] s_byte_r;
  logic [1:0] s_byte_nxt;
  logic [7:0] s_sh_r;
  logic [7:0] s_sh_nxt;
  logic       s_grp_r;
  logic       s_grp_nxt;
  logic [1:0] s_reg_r;
  logic [1:0] s_reg_nxt;
  logic       s_ack_r;
  logic       s_ack_nxt;
  logic       s_en;
  logic       s_wr;
  logic       s_hit;

  // the slave lives in both serial modes, also while our own master runs
  assign s_en  = (mode == MODE_MASTER) || (mode == MODE_SLAVE);
  assign s_hit = !s_sh_r[0] && ((s_sh_r[7:1] == slv_addr_a) || (s_sh_r[7:1] == slv_addr_b));

  always_comb begin
    s_act_nxt  = s_act_r;
    s_bit_nxt  = s_bit_r;
    s_byte_nxt = s_byte_r;
    s_sh_nxt   = s_sh_r;
    s_grp_nxt  = s_grp_r;
    s_reg_nxt  = s_reg_r;
    s_ack_nxt  = s_ack_r;
    s_wr       = 1'b0;
    if (!s_en || (scl_f && !sda_q_r && sda_f)) begin
      s_act_nxt = 1'b0;
      s_ack_nxt = 1'b0;
    end else if (scl_q_r && scl_f && sda_q_r && !sda_f) begin
      s_act_nxt  = 1'b1;
      s_bit_nxt  = 4'h0;
      s_byte_nxt = 2'h0;
      s_ack_nxt  = 1'b0;
    end else if (s_act_r && !scl_q_r && scl_f && !s_bit_r[3]) begin
      s_sh_nxt  = {s_sh_r[6:0], sda_f};
      s_bit_nxt = s_bit_r + 4'h1;
    end else if (s_act_r && scl_q_r && !scl_f) begin
      if (s_bit_r == 4'h8) begin
        s_bit_nxt = 4'h9;
        if (s_byte_r == 2'h0) begin
          s_ack_nxt = s_hit;
          s_act_nxt = s_hit;
          s_grp_nxt = s_sh_r[1];
        end else if (s_byte_r == 2'h1) begin
          s_ack_nxt = 1'b1;
          s_reg_nxt = s_sh_r[1:0];
        end else begin
          s_ack_nxt = 1'b1;
          s_wr      = 1'b1;
          s_reg_nxt = s_reg_r + 2'h1;
        end
      end else if (s_bit_r == 4'h9) begin
        s_ack_nxt = 1'b0;
        s_bit_nxt = 4'h0;
        if (s_byte_r != 2'h2) begin
          s_byte_nxt = s_byte_r + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      scl_q_r  <= 1'b1;
      sda_q_r  <= 1'b1;
      s_act_r  <= 1'b0;
      s_bit_r  <= 4'h0;
      s_byte_r <= 2'h0;
      s_sh_r   <= 8'h00;
      s_grp_r  <= 1'b0;
      s_reg_r  <= 2'h0;
      s_ack_r  <= 1'b0;
    end else begin
      scl_q_r  <= scl_f;
      sda_q_r  <= sda_f;
      s_act_r  <= s_act_nxt;
      s_bit_r  <= s_bit_nxt;
      s_byte_r <= s_byte_nxt;
      s_sh_r   <= s_sh_nxt;
      s_grp_r  <= s_grp_nxt;
      s_reg_r  <= s_reg_nxt;
      s_ack_r  <= s_ack_nxt;
    end
  end

  // ==========================================================================
  // channel settings and apb registers
  logic [3:0]  boost_r   [NUM_CH];
  logic [3:0]  boost_nxt [NUM_CH];
  logic [31:0] boost_out_nxt;
  logic [31:0] boost_out_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_val;
  logic        a_boost;
  logic        a_ok;
  logic [2:0]  a_idx;
  logic        a_wr;

  assign a_boost = (PADDR_I >= REG_BOOST_CH0) && (PADDR_I <= REG_BOOST_CH7) && (PADDR_I[1:0] == 2'h0);
  assign a_ok    = a_boost || (PADDR_I == REG_STATUS);
  assign a_idx   = 3'(PADDR_I[5:2] - REG_BOOST_CH0[5:2]);
  assign a_wr    = PSEL_I && PENABLE_I && PWRITE_I && a_boost;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (a_boost) begin
      rd_val[3:0] = boost_r[a_idx];
    end else if (PADDR_I == REG_STATUS) begin
      rd_val[ST_MODE_LSB +: 2] = mode;
      rd_val[ST_BUSY_BIT]      = !(m_st_r[0] || m_st_r[4] || m_st_r[5]);
      rd_val[ST_OK_BIT]        = m_st_r[4];
      rd_val[ST_FAIL_BIT]      = m_st_r[5];
      rd_val[ST_CAP_BIT]       = cap_done;
      rd_val[ST_ADDR_LSB +: 7] = slv_addr_a;
    end
  end

  // one register per channel; the writer that lands last in a cycle is the serial slave
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
      always_comb begin
        boost_nxt[gc] = boost_r[gc];
        if (a_wr && a_idx == 3'(gc)) begin
          boost_nxt[gc] = PWDATA_I[3:0];
        end
        if (ee_wr && ee_ch == 3'(gc)) begin
          boost_nxt[gc] = m_sh_r[3:0];
        end
        if (s_wr && {s_grp_r, s_reg_r} == 3'(gc)) begin
          boost_nxt[gc] = s_sh_r[3:0];
        end
        // pin mode ignores the stored value and uses the group's strap pair
        if (mode == MODE_PIN) begin
          boost_out_nxt[gc*4 +: 4] = (gc < 4) ? cap_r[7:4] : cap_r[3:0];
        end else begin
          boost_out_nxt[gc*4 +: 4] = boost_r[gc];
        end
      end

      always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          boost_r[gc] <= 4'h0;
        end else begin
          boost_r[gc] <= boost_nxt[gc];
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      boost_out_r <= 32'h0000_0000;
      prdata_r    <= 32'h0000_0000;
    end else begin
      boost_out_r <= boost_out_nxt;
      prdata_r    <= (PSEL_I && !PENABLE_I) ? rd_val : prdata_r;
    end
  end

  // ==========================================================================
  // outputs
  assign PRDATA_O        = prdata_r;
  assign PREADY_O        = 1'b1;
  assign PSLVERR_O       = PSEL_I && PENABLE_I && !a_ok;
  assign BOOST_STEP_O    = boost_out_r;
  assign SCL_O           = 1'b0;
  assign SCL_OE_O        = m_scl_low_r;
  assign SDA_O           = 1'b0;
  assign SDA_OE_O        = m_sda_low_r || s_ack_r;
  assign ALL_DONE_N_O    = 1'b0;
  // released unless the read finished cleanly, the load time has run out and the mode is master
  assign ALL_DONE_N_OE_O = m_st_r[4] && ld_due && (mode == MODE_MASTER);

endmodule // rcl_cfg_loader

`default_nettype wire

/* File: hw/rcl_in_filter.sv */
// two-flop synchroniser followed by a per-bit stability filter
`timescale 1ns/100ps
`default_nettype none

module rcl_in_filter #(
  parameter int           W       = 1,
  parameter int           FILT    = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // ==========================================================================
  // per-bit chain
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic       s1_r;
      logic       s2_r;
      logic       q_r;
      logic       q_nxt;
      logic [3:0] cnt_r;
      logic [3:0] cnt_nxt;

      // a change is taken only after it has stood FILT cycles in a row
      always_comb begin
        cnt_nxt = 4'h0;
        q_nxt   = q_r;
        if (s2_r != q_r) begin
          if (cnt_r == 4'(FILT - 1)) begin
            q_nxt = s2_r;
          end else begin
            cnt_nxt = cnt_r + 4'h1;
          end
        end
      end

      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          s1_r  <= RST_VAL[gi];
          s2_r  <= RST_VAL[gi];
          q_r   <= RST_VAL[gi];
          cnt_r <= 4'h0;
        end else begin
          s1_r  <= d_i[gi];
          s2_r  <= s1_r;
          q_r   <= q_nxt;
          cnt_r <= cnt_nxt;
        end
      end

      assign q_o[gi] = q_r;
    end
  endgenerate

endmodule // rcl_in_filter

`default_nettype wire

/* File: hw/rcl_pkg.sv */
// constants and types shared by the redriver configuration loader
package rcl_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_MHZ       = 100;
  localparam int CLK_NS        = 10;
  localparam int T_LOW_NS      = 1900;
  localparam int T_HIGH_NS     = 1400;
  localparam int T_SU_STA_NS   = 2000;
  localparam int T_HD_STA_NS   = 1500;
  localparam int T_HD_DAT_NS   = 500;
  localparam int T_SU_STO_NS   = 1500;
  localparam int T_GLITCH_NS   = 50;
  localparam int T_EEPROM_US   = 7500;
  localparam int LOAD_CYC_DFLT = T_EEPROM_US * CLK_MHZ;

  // terminal counts of the 8-bit phase timer (nominal figures, rounded down)
  localparam logic [7:0] TC_LOW    = 8'((T_LOW_NS * CLK_MHZ) / 1000 - 1);
  localparam logic [7:0] TC_HIGH   = 8'((T_HIGH_NS * CLK_MHZ) / 1000 - 1);
  localparam logic [7:0] TC_SU_STA = 8'((T_SU_STA_NS * CLK_MHZ) / 1000 - 1);
  localparam logic [7:0] TC_HD_STA = 8'((T_HD_STA_NS * CLK_MHZ) / 1000 - 1);
  localparam logic [7:0] TC_HD_DAT = 8'((T_HD_DAT_NS * CLK_MHZ) / 1000 - 1);
  localparam logic [7:0] TC_SU_STO = 8'((T_SU_STO_NS * CLK_MHZ) / 1000 - 1);

  // a spike must be outlasted by one more cycle to be believed
  localparam int BUS_FILT_CYC = T_GLITCH_NS / CLK_NS + 1;
  localparam int PIN_FILT_CYC = 1;
  localparam logic [2:0] CAP_DLY = 3'h4;

  // ==========================================================================
  // modes and addresses
  localparam logic [1:0] MODE_PIN    = 2'h0;
  localparam logic [1:0] MODE_MASTER = 2'h1;
  localparam logic [1:0] MODE_SLAVE  = 2'h2;

  localparam logic [7:0] EE_DEV_WR   = 8'hA0;
  localparam logic [7:0] EE_DEV_RD   = 8'hA1;
  localparam logic [7:0] EE_WORD     = 8'h00;
  localparam logic [3:0] EE_STEP_WA  = 4'h1;
  localparam logic [3:0] EE_STEP_RS  = 4'h2;
  localparam logic [3:0] EE_RD_FIRST = 4'h3;
  localparam logic [3:0] EE_RD_LAST  = 4'hA;

  localparam logic [6:0] SLV_BASE    = 7'h18;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_STATUS    = 8'h00;
  localparam logic [7:0] REG_BOOST_CH0 = 8'h10;
  localparam logic [7:0] REG_BOOST_CH7 = 8'h2C;
  localparam int ST_MODE_LSB  = 0;
  localparam int ST_BUSY_BIT  = 2;
  localparam int ST_OK_BIT    = 3;
  localparam int ST_FAIL_BIT  = 4;
  localparam int ST_CAP_BIT   = 5;
  localparam int ST_ADDR_LSB  = 8;

  localparam int NUM_CH = 8;

  typedef enum logic [5:0] {
    M_IDLE  = 6'h01,
    M_START = 6'h02,
    M_BIT   = 6'h04,
    M_STOP  = 6'h08,
    M_DONE  = 6'h10,
    M_FAIL  = 6'h20
  } rcl_mst_t;

endpackage
